// ==== gpmx_pkg.sv ====
// Purpose: Constants for the eight-bit port with pin multiplexing
// Assumes: 32-bit register port, byte offsets as printed
// Notes: Summary list below names each behaviour kept by the port
//
// Summary of operation
// R1 - Eight pins, direction chosen per bit
// R2 - Reset leaves pins port, input/output/pull-up off
// R3 - All select bits zero means plain port
// R4 - Software never sets two select bits together
// R5 - Selected, enabled interrupt pins work during stop
// R6 - Outside stop, enabled input reaches interrupt always
// R7 - Software disables unused external interrupts
// R8 - Data register eight bits, upper read zero
// R9 - Output-control bit enables pin driver
// R10 - Select one routes interrupt, uart1, serial0 pins
// R11 - Select two bit n routes timer n
// R12 - Select three routes clear-to-send, serial3 bus
// R13 - Registers decoded at fixed offsets 0x00-0x38
// R14 - Open-drain bit: zero push-pull, one open-drain
// R15 - Pull-up bit switches pin pull-up
// R16 - Input bit switches pin input buffer
// R17 - Read returns pin if input enabled, else zero
package gpmx_pkg;
    localparam int GPMX_WIDTH = 8;
    localparam logic [7:0] GPMX_OFF_DATA = 8'h00;
    localparam logic [7:0] GPMX_OFF_OUTEN = 8'h04;
    localparam logic [7:0] GPMX_OFF_FSEL1 = 8'h08;
    localparam logic [7:0] GPMX_OFF_FSEL2 = 8'h0C;
    localparam logic [7:0] GPMX_OFF_FSEL3 = 8'h10;
    localparam logic [7:0] GPMX_OFF_OPEN_DRAIN = 8'h28;
    localparam logic [7:0] GPMX_OFF_PULLUP = 8'h2C;
    localparam logic [7:0] GPMX_OFF_INEN = 8'h38;
    localparam logic [7:0] GPMX_RESET_VALUE = 8'h00;
    localparam logic [7:0] GPMX_FSEL3_MASK = 8'h70;
    localparam int GPMX_BIT_IRQ_ZERO = 3;
    localparam int GPMX_BIT_IRQ_ONE = 7;
    localparam int GPMX_BIT_U1_CLK = 6;
    localparam int GPMX_BIT_U1_RX = 5;
    localparam int GPMX_BIT_U1_TX = 4;
    localparam int GPMX_BIT_S0_CLK = 2;
    localparam int GPMX_BIT_S0_BCLK = 1;
    localparam int GPMX_BIT_S0_BDATA = 0;
    localparam int GPMX_BIT_U1_CTS = 6;
    localparam int GPMX_BIT_S3_BCLK = 5;
    localparam int GPMX_BIT_S3_BDATA = 4;
endpackage

// ==== gpmx_pin_sync.sv ====
// Purpose: Two-stage synchroniser for the pin levels
// Assumes: Pins are asynchronous to mclk
// Notes: First stage is read only by the second
module gpmx_pin_sync #(
    parameter int WIDTH = 8
) (
    input wire logic mclk, // System clock
    input wire logic resetn, // Synchronous reset, active low
    input wire logic [WIDTH-1:0] async_in, // Raw pin levels
    output logic [WIDTH-1:0] sync_out // Synchronised levels
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            meta_reg <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// ==== gpmx_port.sv ====
// Purpose: Eight-bit GPIO port with three function-select registers
// Assumes: Peripherals and the pad ring are outside; stop_mode from clock control
// Notes: Pad outputs are registered, so they trail register writes by one cycle
module gpmx_port
    import gpmx_pkg::*;
#(
    parameter int WIDTH = gpmx_pkg::GPMX_WIDTH
) (
    input wire logic mclk, // System clock, 50 MHz
    input wire logic resetn, // Synchronous reset, active low
    input wire logic [7:0] addr, // Register byte offset
    input wire logic [31:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    output logic [31:0] rdata, // Read data, cycle after rd
    input wire logic stop_mode, // Device is in stop mode
    input wire logic stop_pin_drive_hold, // Standby pin-drive-stop bit
    input wire logic [WIDTH-1:0] pin_in, // Pad input levels
    output logic [WIDTH-1:0] pin_out, // Pad output value
    output logic [WIDTH-1:0] pin_oe, // Pad drive enable
    output logic [WIDTH-1:0] pin_pullup, // Pad pull-up enable
    output logic [WIDTH-1:0] pin_ie, // Pad input buffer enable
    output logic ext_irq_zero, // External interrupt 0 level
    output logic ext_irq_one, // External interrupt 1 level
    input wire logic uart1_serial_clock_out, // UART1 clock from peripheral
    input wire logic uart1_serial_clock_oe, // UART1 clock drive enable
    output logic uart1_serial_clock_in, // UART1 clock to peripheral
    output logic uart1_receive, // UART1 receive data
    input wire logic uart1_transmit, // UART1 transmit data
    output logic uart1_clear_to_send, // UART1 clear-to-send
    input wire logic serial0_clock_out, // Serial 0 clock out
    input wire logic serial0_clock_oe, // Serial 0 clock drive enable
    output logic serial0_clock_in, // Serial 0 clock in
    input wire logic serial0_busclk_or_in_out, // Serial 0 bus clock out
    input wire logic serial0_busclk_or_in_oe, // Serial 0 bus clock drive enable
    output logic serial0_busclk_or_in, // Serial 0 bus clock or serial in
    input wire logic serial0_busdata_or_out_out, // Serial 0 data out
    input wire logic serial0_busdata_or_out_oe, // Serial 0 data drive enable
    output logic serial0_busdata_or_out_in, // Serial 0 bus data in
    input wire logic serial3_bus_clock_out, // Serial 3 bus clock out
    input wire logic serial3_bus_clock_oe, // Serial 3 bus clock drive enable
    output logic serial3_bus_clock_in, // Serial 3 bus clock in
    input wire logic serial3_bus_data_out, // Serial 3 bus data out
    input wire logic serial3_bus_data_oe, // Serial 3 bus data drive enable
    output logic serial3_bus_data_in, // Serial 3 bus data in
    input wire logic [WIDTH-1:0] timer_output // Timer channel n outputs
);
    import gpmx_pkg::*;

    logic [WIDTH-1:0] pin_data_reg;
    logic [WIDTH-1:0] output_enable_reg;
    logic [WIDTH-1:0] function_select_one_reg;
    logic [WIDTH-1:0] function_select_two_reg;
    logic [WIDTH-1:0] function_select_three_reg;
    logic [WIDTH-1:0] open_drain_control_reg;
    logic [WIDTH-1:0] pullup_control_reg;
    logic [WIDTH-1:0] input_enable_reg;
    logic [WIDTH-1:0] pin_sync;
    logic [WIDTH-1:0] pin_seen;
    logic [WIDTH-1:0] alt_out;
    logic [WIDTH-1:0] alt_oe;
    logic [WIDTH-1:0] drive_val;
    logic [WIDTH-1:0] drive_en;
    logic [31:0] rdata_next;
    logic [WIDTH-1:0] wbyte;
    logic irq0_next;
    logic irq1_next;

    assign wbyte = wdata[WIDTH-1:0];

    gpmx_pin_sync #(
        .WIDTH(WIDTH)
    ) gpmx_pin_sync_inst (
        .mclk(mclk),
        .resetn(resetn),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    // Input buffer off gates the level to zero
    assign pin_seen = pin_sync & input_enable_reg; // R16 R17

    // Register writes; reset leaves everything port, all buffers off
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            pin_data_reg <= GPMX_RESET_VALUE; // R2
            output_enable_reg <= GPMX_RESET_VALUE; // R2
            function_select_one_reg <= GPMX_RESET_VALUE;
            function_select_two_reg <= GPMX_RESET_VALUE;
            function_select_three_reg <= GPMX_RESET_VALUE;
            open_drain_control_reg <= GPMX_RESET_VALUE;
            pullup_control_reg <= GPMX_RESET_VALUE; // R2
            input_enable_reg <= GPMX_RESET_VALUE; // R2
        end
        else if (wr)
        begin
            case (addr) // R13
                GPMX_OFF_DATA: pin_data_reg <= wbyte; // R8
                GPMX_OFF_OUTEN: output_enable_reg <= wbyte; // R9 R1
                GPMX_OFF_FSEL1: function_select_one_reg <= wbyte;
                GPMX_OFF_FSEL2: function_select_two_reg <= wbyte;
                GPMX_OFF_FSEL3: function_select_three_reg <= wbyte & GPMX_FSEL3_MASK; // R12
                GPMX_OFF_OPEN_DRAIN: open_drain_control_reg <= wbyte; // R14
                GPMX_OFF_PULLUP: pullup_control_reg <= wbyte; // R15
                GPMX_OFF_INEN: input_enable_reg <= wbyte; // R16
                default:
                begin
                end
            endcase
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb
    begin
        rdata_next = 32'h0000_0000;
        case (addr) // R13
            GPMX_OFF_DATA: rdata_next[WIDTH-1:0] = pin_seen; // R17 R8
            GPMX_OFF_OUTEN: rdata_next[WIDTH-1:0] = output_enable_reg;
            GPMX_OFF_FSEL1: rdata_next[WIDTH-1:0] = function_select_one_reg;
            GPMX_OFF_FSEL2: rdata_next[WIDTH-1:0] = function_select_two_reg;
            GPMX_OFF_FSEL3: rdata_next[WIDTH-1:0] = function_select_three_reg; // R12
            GPMX_OFF_OPEN_DRAIN: rdata_next[WIDTH-1:0] = open_drain_control_reg;
            GPMX_OFF_PULLUP: rdata_next[WIDTH-1:0] = pullup_control_reg; // R15
            GPMX_OFF_INEN: rdata_next[WIDTH-1:0] = input_enable_reg; // R16
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!resetn)
            rdata <= 32'h0000_0000;
        else if (rd)
            rdata <= rdata_next;
        else
            rdata <= 32'h0000_0000;
    end

    // Alternate-function drive per pin; timer bits only from select two
    always_comb
    begin
        alt_out = '0;
        alt_oe = '0;
        alt_out[GPMX_BIT_S0_BDATA] = serial0_busdata_or_out_out; // R10
        alt_oe[GPMX_BIT_S0_BDATA] = serial0_busdata_or_out_oe;
        alt_out[GPMX_BIT_S0_BCLK] = serial0_busclk_or_in_out;
        alt_oe[GPMX_BIT_S0_BCLK] = serial0_busclk_or_in_oe;
        alt_out[GPMX_BIT_S0_CLK] = serial0_clock_out;
        alt_oe[GPMX_BIT_S0_CLK] = serial0_clock_oe;
        alt_out[GPMX_BIT_U1_TX] = uart1_transmit;
        alt_oe[GPMX_BIT_U1_TX] = 1'b1;
        alt_out[GPMX_BIT_U1_CLK] = uart1_serial_clock_out;
        alt_oe[GPMX_BIT_U1_CLK] = uart1_serial_clock_oe;
    end

    // Priority among selects is only a safe default; software must keep them exclusive
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++)
        begin : g_pin
            always_comb
            begin
                if (function_select_two_reg[gi]) // R11 R4
                begin
                    drive_val[gi] = timer_output[gi];
                    drive_en[gi] = 1'b1;
                end
                else if (function_select_three_reg[gi])
                begin
                    // Serial 3 bus lines sit on bits 5 and 4, clear-to-send is input only
                    drive_val[gi] = (gi == GPMX_BIT_S3_BCLK) ? serial3_bus_clock_out :
                                    serial3_bus_data_out; // R12
                    drive_en[gi] = (gi == GPMX_BIT_S3_BCLK) ? serial3_bus_clock_oe :
                                   (gi == GPMX_BIT_S3_BDATA) ? serial3_bus_data_oe : 1'b0;
                end
                else if (function_select_one_reg[gi])
                begin
                    drive_val[gi] = alt_out[gi]; // R10
                    drive_en[gi] = alt_oe[gi];
                end
                else
                begin
                    drive_val[gi] = pin_data_reg[gi]; // R3 R17
                    drive_en[gi] = output_enable_reg[gi]; // R9 R1
                end
            end

            // Open drain drives only low; a one releases the pin
            always_ff @(posedge mclk)
            begin
                if (!resetn)
                begin
                    pin_out[gi] <= 1'b0;
                    pin_oe[gi] <= 1'b0; // R2
                end
                else
                begin
                    pin_out[gi] <= drive_val[gi];
                    pin_oe[gi] <= drive_en[gi] &
                                  ~(open_drain_control_reg[gi] & drive_val[gi]); // R14
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            pin_pullup <= '0;
            pin_ie <= '0;
        end
        else
        begin
            pin_pullup <= pullup_control_reg; // R15
            // Stop with drive hold keeps only selected interrupt inputs alive
            pin_ie <= (stop_mode && stop_pin_drive_hold) ?
                      (input_enable_reg & function_select_one_reg &
                       ((WIDTH'(1) << GPMX_BIT_IRQ_ZERO) | (WIDTH'(1) << GPMX_BIT_IRQ_ONE))) :
                      input_enable_reg; // R5 R16
        end
    end

    // Outside stop the enabled level reaches interrupt logic regardless of select one
    assign irq0_next = pin_seen[GPMX_BIT_IRQ_ZERO] &
        (~stop_mode | function_select_one_reg[GPMX_BIT_IRQ_ZERO]); // R5 R6
    assign irq1_next = pin_seen[GPMX_BIT_IRQ_ONE] &
        (~stop_mode | function_select_one_reg[GPMX_BIT_IRQ_ONE]); // R5 R6

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            ext_irq_zero <= 1'b0;
            ext_irq_one <= 1'b0;
            uart1_serial_clock_in <= 1'b0;
            uart1_receive <= 1'b0;
            uart1_clear_to_send <= 1'b0;
            serial0_clock_in <= 1'b0;
            serial0_busclk_or_in <= 1'b0;
            serial0_busdata_or_out_in <= 1'b0;
            serial3_bus_clock_in <= 1'b0;
            serial3_bus_data_in <= 1'b0;
        end
        else
        begin
            ext_irq_zero <= irq0_next;
            ext_irq_one <= irq1_next;
            uart1_serial_clock_in <= pin_seen[GPMX_BIT_U1_CLK] &
                                     function_select_one_reg[GPMX_BIT_U1_CLK];
            uart1_receive <= pin_seen[GPMX_BIT_U1_RX] &
                             function_select_one_reg[GPMX_BIT_U1_RX]; // R10
            uart1_clear_to_send <= pin_seen[GPMX_BIT_U1_CTS] &
                                   function_select_three_reg[GPMX_BIT_U1_CTS]; // R12
            serial0_clock_in <= pin_seen[GPMX_BIT_S0_CLK] &
                                function_select_one_reg[GPMX_BIT_S0_CLK];
            serial0_busclk_or_in <= pin_seen[GPMX_BIT_S0_BCLK] &
                                    function_select_one_reg[GPMX_BIT_S0_BCLK];
            serial0_busdata_or_out_in <= pin_seen[GPMX_BIT_S0_BDATA] &
                                         function_select_one_reg[GPMX_BIT_S0_BDATA];
            serial3_bus_clock_in <= pin_seen[GPMX_BIT_S3_BCLK] &
                                    function_select_three_reg[GPMX_BIT_S3_BCLK];
            serial3_bus_data_in <= pin_seen[GPMX_BIT_S3_BDATA] &
                                   function_select_three_reg[GPMX_BIT_S3_BDATA];
        end
    end

    property p_reset_quiet;
        @(posedge mclk) !resetn |=> (pin_oe == '0 && pin_ie == '0 && pin_pullup == '0);
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("pins active after reset"); // R2

    property p_port_drive;
        @(posedge mclk) disable iff (!resetn)
        (function_select_one_reg == '0 && function_select_two_reg == '0 &&
         function_select_three_reg == '0 && open_drain_control_reg == '0)
        |=> pin_oe == $past(output_enable_reg) && pin_out == $past(pin_data_reg);
    endproperty
    a_port_drive: assert property (p_port_drive) else $error("port drive mismatch"); // R3

    property p_timer_route;
        @(posedge mclk) disable iff (!resetn)
        (function_select_two_reg[0] && !open_drain_control_reg[0])
        |=> pin_out[0] == $past(timer_output[0]) && pin_oe[0];
    endproperty
    a_timer_route: assert property (p_timer_route) else $error("timer not routed"); // R11

    property p_data_read;
        @(posedge mclk) disable iff (!resetn)
        (rd && addr == GPMX_OFF_DATA) |=> rdata == {24'h000000, $past(pin_seen)};
    endproperty
    a_data_read: assert property (p_data_read) else $error("data read wrong"); // R17

    property p_input_gate;
        @(posedge mclk) disable iff (!resetn)
        (rd && addr == GPMX_OFF_DATA && input_enable_reg == '0) |=> rdata == 32'h0;
    endproperty
    a_input_gate: assert property (p_input_gate) else $error("disabled input read"); // R16

    property p_fsel3_mask;
        @(posedge mclk) disable iff (!resetn)
        (rd && addr == GPMX_OFF_FSEL3) |=> (rdata & 32'hFFFF_FF8F) == 32'h0;
    endproperty
    a_fsel3_mask: assert property (p_fsel3_mask) else $error("select three stray bits"); // R12

    property p_stop_irq;
        @(posedge mclk) disable iff (!resetn)
        (stop_mode && !function_select_one_reg[GPMX_BIT_IRQ_ZERO]) |=> !ext_irq_zero;
    endproperty
    a_stop_irq: assert property (p_stop_irq) else $error("unselected irq in stop"); // R5

    property p_run_irq;
        @(posedge mclk) disable iff (!resetn)
        !stop_mode |=> ext_irq_zero == $past(pin_seen[GPMX_BIT_IRQ_ZERO]);
    endproperty
    a_run_irq: assert property (p_run_irq) else $error("irq level lost"); // R6

    property p_open_drain;
        @(posedge mclk) disable iff (!resetn)
        |(open_drain_control_reg & drive_val)
        |=> (pin_oe & $past(open_drain_control_reg & drive_val)) == '0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open drain drove high"); // R14

    property p_upper_zero;
        @(posedge mclk) disable iff (!resetn) rd |=> rdata[31:8] == 24'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits set"); // R8

    c_write_out: cover property (@(posedge mclk) wr && addr == GPMX_OFF_OUTEN ##1 pin_oe != 0);
    c_timer: cover property (@(posedge mclk) function_select_two_reg != 0);
    c_stop_irq: cover property (@(posedge mclk) stop_mode && ext_irq_one);
    c_read: cover property (@(posedge mclk) rd ##1 rdata != 0);
endmodule

// ==== gpmx_pads.sv ====
// Purpose: Pad ring model that resolves each port pin from all its drivers
// Assumes: Port drive wins, then the bench's outside driver, then the pull-up
// Notes: An undriven pin with no pull-up toggles every cycle so that a stale
// Notes: level can never pass for a real one
module gpmx_pads (
    input wire logic mclk, // System clock
    input wire logic [7:0] pin_out, // Port output value
    input wire logic [7:0] pin_oe, // Port drive enable
    input wire logic [7:0] pin_pullup, // Pull-up enable
    input wire logic [7:0] ext_en, // Outside driver enable
    input wire logic [7:0] ext_val, // Outside driver value
    output logic [7:0] pin_level // Resolved pad level
);
    timeunit 1ns;
    timeprecision 100ps;
    logic float_reg = 1'b0;

    always @(posedge mclk)
    begin
        float_reg <= ~float_reg;
    end

    // Open-drain release is seen here as oe low, so the outside driver, or else the pull-up, takes over
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (pin_oe[i])
                pin_level[i] = pin_out[i];
            else if (ext_en[i])
                pin_level[i] = ext_val[i];
            else if (pin_pullup[i])
                pin_level[i] = 1'b1;
            else
                pin_level[i] = float_reg;
        end
    end
endmodule

// ==== gpmx_port_test.sv ====
// Purpose: Self-checking bench for the eight-bit port with pin multiplexing
// Assumes: Register port with read data one cycle after the read strobe
// Notes: Reset values are checked first, then register rows, pad, timer, interrupt, select and reset cases
module gpmx_port_test;
    timeunit 1ns;
    timeprecision 100ps;
    import gpmx_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} gpmx_row_s;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic stop_mode = 1'b0;
    logic hold = 1'b0;
    logic [7:0] ext_en = 8'h00;
    logic [7:0] ext_val = 8'h00;
    logic [7:0] tmr = 8'h00;
    logic [12:0] per = 13'h0000;
    logic [31:0] rdata;
    logic [7:0] pin_level, pin_out, pin_oe, pin_pullup, pin_ie;
    logic irq0, irq1, u1rx, u1cts;
    logic [5:0] sin;
    logic [31:0] got;
    int failures = 0;
    int checks_done = 0;
    logic [7:0] offs [8] = '{GPMX_OFF_DATA, GPMX_OFF_OUTEN, GPMX_OFF_FSEL1, GPMX_OFF_FSEL2,
        GPMX_OFF_FSEL3, GPMX_OFF_OPEN_DRAIN, GPMX_OFF_PULLUP, GPMX_OFF_INEN};
    // Each select is cleared before the next one is set, so no pin ever has two
    gpmx_row_s rows [11] = '{
        '{GPMX_OFF_OUTEN, 32'hFFFF_FFFF, 32'h0000_00FF},
        '{GPMX_OFF_FSEL1, 32'h0000_01A5, 32'h0000_00A5},
        '{GPMX_OFF_FSEL1, 32'h0000_0000, 32'h0000_0000},
        '{GPMX_OFF_FSEL2, 32'h0000_005A, 32'h0000_005A},
        '{GPMX_OFF_FSEL2, 32'h0000_0000, 32'h0000_0000},
        '{GPMX_OFF_FSEL3, 32'hFFFF_FFFF, 32'h0000_0070},
        '{GPMX_OFF_FSEL3, 32'h0000_0000, 32'h0000_0000},
        '{GPMX_OFF_OPEN_DRAIN, 32'h0000_010F, 32'h0000_000F},
        '{GPMX_OFF_PULLUP, 32'h0000_00F0, 32'h0000_00F0},
        '{GPMX_OFF_INEN, 32'h0000_00FF, 32'h0000_00FF},
        '{8'h14, 32'h0000_00FF, 32'h0000_0000}};

    gpmx_port gpmx_port_inst (.mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .stop_mode(stop_mode), .stop_pin_drive_hold(hold),
        .pin_in(pin_level), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
        .pin_ie(pin_ie), .ext_irq_zero(irq0), .ext_irq_one(irq1),
        .uart1_serial_clock_out(per[0]), .uart1_serial_clock_oe(per[1]),
        .uart1_serial_clock_in(sin[5]), .uart1_receive(u1rx), .uart1_transmit(per[2]),
        .uart1_clear_to_send(u1cts), .serial0_clock_out(per[3]), .serial0_clock_oe(per[4]),
        .serial0_clock_in(sin[4]), .serial0_busclk_or_in_out(per[5]),
        .serial0_busclk_or_in_oe(per[6]), .serial0_busclk_or_in(sin[3]),
        .serial0_busdata_or_out_out(per[7]), .serial0_busdata_or_out_oe(per[8]),
        .serial0_busdata_or_out_in(sin[2]), .serial3_bus_clock_out(per[9]),
        .serial3_bus_clock_oe(per[10]), .serial3_bus_clock_in(sin[1]),
        .serial3_bus_data_out(per[11]), .serial3_bus_data_oe(per[12]), .serial3_bus_data_in(sin[0]),
        .timer_output(tmr));

    gpmx_pads gpmx_pads_inst (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .pin_level(pin_level));

    always #10 mclk = ~mclk;

    task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_pin(input string n, input logic [7:0] e, input logic [7:0] g);
        chk_word(n, {24'h000000, e}, {24'h000000, g});
    endtask

    // Ends on the edge that takes the write, so back-to-back calls leave a gap
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic do_reset();
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
    endtask

    task automatic reset_check();
        for (int i = 0; i < 8; i++)
        begin
            rd_reg(offs[i], got);
            chk_word("reset value", 32'h0000_0000, got);
        end
        chk_pin("reset drive", 8'h00, pin_oe | pin_ie | pin_pullup);
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        #200000;
        failures++;
        close_out();
    end

    initial
    begin
        do_reset();
        reset_check();
        foreach (rows[i])
        begin
            wr_reg(rows[i].a, rows[i].d);
            rd_reg(rows[i].a, got);
            chk_word("register", rows[i].e, got);
        end
        ext_en <= 8'h0C;
        ext_val <= 8'h08;
        wr_reg(GPMX_OFF_DATA, 32'h0000_003C);
        settle(2);
        chk_pin("drive enable", 8'hF3, pin_oe);
        chk_pin("driven value", 8'h30, pin_out & pin_oe);
        chk_pin("pull-up", 8'hF0, pin_pullup);
        chk_pin("input buffer", 8'hFF, pin_ie);
        settle(3);
        rd_reg(GPMX_OFF_DATA, got);
        chk_word("pin read", 32'h0000_0038, got);
        wr_reg(GPMX_OFF_INEN, 32'h0000_000F);
        settle(3);
        rd_reg(GPMX_OFF_DATA, got);
        chk_word("masked read", 32'h0000_0008, got);
        wr_reg(GPMX_OFF_OPEN_DRAIN, 32'h0000_0000);
        tmr <= 8'h96;
        wr_reg(GPMX_OFF_FSEL2, 32'h0000_00FF);
        settle(2);
        chk_pin("timer route", 8'h96, pin_out & pin_oe);
        wr_reg(GPMX_OFF_FSEL2, 32'h0000_0000);
        settle(2);
        chk_pin("port again", 8'h3C, pin_out & pin_oe);
        wr_reg(GPMX_OFF_OUTEN, 32'h0000_0000);
        ext_en <= 8'hFF;
        ext_val <= 8'h88;
        wr_reg(GPMX_OFF_INEN, 32'h0000_0088);
        settle(4);
        chk_pin("irq run", 8'h03, {6'h00, irq1, irq0});
        @(posedge mclk);
        stop_mode <= 1'b1;
        hold <= 1'b1;
        settle(4);
        chk_pin("irq stop unselected", 8'h00, {6'h00, irq1, irq0});
        chk_pin("stop input buffer off", 8'h00, pin_ie);
        wr_reg(GPMX_OFF_FSEL1, 32'h0000_0088);
        settle(4);
        chk_pin("irq stop high", 8'h03, {6'h00, irq1, irq0});
        chk_pin("stop input buffer kept", 8'h88, pin_ie);
        ext_val <= 8'h00;
        settle(4);
        chk_pin("irq stop low", 8'h00, {6'h00, irq1, irq0});
        @(posedge mclk);
        stop_mode <= 1'b0;
        hold <= 1'b0;
        ext_en <= 8'h60;
        ext_val <= 8'h60;
        per[2] <= 1'b1;
        wr_reg(GPMX_OFF_INEN, 32'h0000_0060);
        wr_reg(GPMX_OFF_FSEL1, 32'h0000_0030);
        wr_reg(GPMX_OFF_FSEL3, 32'h0000_0040);
        settle(4);
        chk_pin("uart inputs", 8'h03, {6'h00, u1rx, u1cts});
        chk_pin("uart transmit", 8'h10, pin_out & pin_oe & 8'h10);
        @(posedge mclk);
        per[2] <= 1'b0;
        settle(2);
        chk_pin("uart transmit low", 8'h10, pin_oe & 8'h10);
        chk_pin("uart transmit value", 8'h00, pin_out & 8'h10);
        // Select three is cleared first so no pin ever sits in two selects
        @(posedge mclk);
        ext_en <= 8'hFF;
        ext_val <= 8'h77;
        wr_reg(GPMX_OFF_INEN, 32'h0000_00FF);
        wr_reg(GPMX_OFF_FSEL3, 32'h0000_0000);
        wr_reg(GPMX_OFF_FSEL1, 32'h0000_0047);
        wr_reg(GPMX_OFF_FSEL3, 32'h0000_0030);
        settle(4);
        chk_pin("serial inputs", 8'h3F, {2'b00, sin});
        @(posedge mclk);
        per <= 13'h1FFF;
        settle(2);
        chk_pin("serial drive high", 8'h77, pin_out & pin_oe);
        @(posedge mclk);
        per <= 13'h1552;
        settle(2);
        chk_pin("serial drive low", 8'h77, pin_oe & ~pin_out);
        do_reset();
        reset_check();
        close_out();
    end
endmodule
